// File: dv/mpsr_fieldbus_model.sv
`timescale 1ns/100ps

module mpsr_fieldbus_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic raise_cmd,
   input wire logic lower_cmd,
   output logic [15:0] control_word
);
   // The controller refreshes its word once a cycle, so commands land late.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         control_word <= 16'h0000;
      end else begin
         control_word <= {1'b0, lower_cmd, raise_cmd, 13'h0000};
      end
   end
endmodule : mpsr_fieldbus_model

// File: dv/tb_motor_pot_setpoint_ramp.sv
`timescale 1ns/100ps
`include "mpsr_cfg.svh"

module tb_motor_pot_setpoint_ramp;
   import mpsr_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   mpsr_bus_type bus = '0;
   mpsr_io_type io;
   logic motor_on = 1'b0;
   logic auto_sel = 1'b1;
   logic raise = 1'b0;
   logic lower = 1'b0;
   logic [15:0] fb = 16'h0000;
   logic [15:0] an = 16'h0000;
   logic [15:0] din = 16'h0000;
   logic [15:0] cw, rdata, ramped, active, nv_data, s;
   logic nv_req;
   logic rd_seen = 1'b0;
   logic [3:0] rd_addr = 4'h0;
   logic nv_valid = 1'b0;
   logic [15:0] nv_img = 16'h0000;
   logic [15:0] exp_q[$];
   string name_q[$];
   int err_total = 0;
   int n_tests = 0;
   logic [15:0] reg_exp [11] = '{16'h0006, 16'h001d, 16'h001e, 16'h0000,
      16'h0064, 16'h0064, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000};

   assign io = '{control_word: cw, digital_in: din,
      fieldbus_receive_word_two: fb, analog_in0: an};

   mpsr_fieldbus_model partner (.clock(clock), .rst_b(rst_b),
      .raise_cmd(raise), .lower_cmd(lower), .control_word(cw));

   // A short tick keeps every ramp count small enough to reach in a run.
   mpsr_top #(.CTRL_TICK_CYCLES(4)) dut (.clock(clock), .rst_b(rst_b),
      .bus(bus), .rdata(rdata), .io(io), .motor_on(motor_on),
      .automatic_mode_select(auto_sel), .nv_restore_valid(nv_valid),
      .nv_restore_data(nv_img), .pot_ramped_setpoint(ramped),
      .active_main_setpoint(active), .nv_store_req(nv_req),
      .nv_store_data(nv_data));

   // Free-running control clock.
   initial begin
      forever begin
         #20 clock = ~clock;
      end
   end

   task summarize();
      $display("Checks %0d, errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize

   task check(input string n, input logic [15:0] seen, input logic [15:0] e);
      n_tests++;
      if (seen !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", n, e, seen);
      end
   endtask : check

   task run(input int n);
      repeat (n) @(posedge clock);
   endtask : run

   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask : wr

   // The note goes in first; the monitor takes it when the data appear.
   task rd(input logic [3:0] a, input logic [15:0] e, input string n);
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clock);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clock);
      bus.rd <= 1'b0;
      run(2);
   endtask : rd

   // Read data stand only in the cycle after the strobe, so look there.
   always @(posedge clock) begin
      if (rd_seen && exp_q.size() > 0) begin
         if (rd_addr == `MPSR_A_RAMPED) begin
            check("ramped pin", ramped, exp_q[0]);
         end
         if (rd_addr == `MPSR_A_ACTIVE) begin
            check("active pin", active, exp_q[0]);
         end
         check(name_q.pop_front(), rdata, exp_q.pop_front());
      end
      if (nv_req && exp_q.size() > 0) begin
         check(name_q.pop_front(), nv_data, exp_q.pop_front());
      end
      rd_seen <= bus.rd;
      rd_addr <= bus.addr;
   end

   // Watchdog sized well above the few hundred cycles the tests need.
   initial begin
      run(5000);
      err_total++;
      summarize();
   end

   // Main sequence.
   initial begin
      void'($urandom(32'hddee));
      fb <= 16'($urandom_range(2000)) - 16'h03e8;
      din <= 16'($urandom);
      an <= 16'($urandom);
      s = 16'($urandom_range(999));
      run(16);
      rst_b <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         rd((i < 10) ? 4'(i) : 4'hd, reg_exp[i], "reg");
      end
      rd(`MPSR_A_ACTIVE, fb, "active");
      rd(`MPSR_A_RAMPED, 16'h0000, "ramped");
      wr(`MPSR_A_START, s);
      motor_on <= 1'b1;
      run(4);
      rd(`MPSR_A_RAMPED, s, "start");
      auto_sel <= 1'b0;
      wr(`MPSR_A_CFG, 16'h0000);
      raise <= 1'b1;
      run(20);
      raise <= 1'b0;
      run(3);
      rd(`MPSR_A_RAMPED, s, "manual");
      auto_sel <= 1'b1;
      raise <= 1'b1;
      run(8);
      rd(`MPSR_A_RAMPED, 16'h05dc, "raise");
      lower <= 1'b1;
      run(8);
      rd(`MPSR_A_RAMPED, 16'h05dc, "both");
      raise <= 1'b0;
      run(8);
      rd(`MPSR_A_RAMPED, 16'hfa24, "lower");
      lower <= 1'b0;
      raise <= 1'b1;
      run(8);
      raise <= 1'b0;
      // Bypass while off, so a lower moves the pot and the restore shows.
      wr(`MPSR_A_CFG, 16'h0009);
      exp_q.push_back(16'h05dc);
      name_q.push_back("store");
      motor_on <= 1'b0;
      run(4);
      lower <= 1'b1;
      run(8);
      lower <= 1'b0;
      motor_on <= 1'b1;
      run(4);
      rd(`MPSR_A_RAMPED, 16'h05dc, "restore");
      // Span equals one tick of travel; rounding halves it to 4 of 8 steps.
      wr(`MPSR_A_DOWN_TIME, 16'h000f);
      wr(`MPSR_A_CFG, 16'h0006);
      lower <= 1'b1;
      run(32);
      lower <= 1'b0;
      rd(`MPSR_A_RAMPED, 16'h05d8, "round");
      wr(`MPSR_A_CFG, 16'h0009);
      exp_q.push_back(16'h05d8);
      name_q.push_back("store2");
      motor_on <= 1'b0;
      nv_img <= s + 16'h0100;
      run(4);
      nv_valid <= 1'b1;
      run(1);
      nv_valid <= 1'b0;
      motor_on <= 1'b1;
      run(4);
      rd(`MPSR_A_RAMPED, s + 16'h0100, "nv restore");
      check("left notes", 16'(exp_q.size()), 16'h0000);
      summarize();
   end
endmodule : tb_motor_pot_setpoint_ramp

// File: src/mpsr_cfg.svh
`ifndef MPSR_CFG_SVH
`define MPSR_CFG_SVH

// Build option: a fieldbus interface is fitted to this drive.
`define MPSR_HAS_FIELDBUS 1'b1

// Clock rate and control cycle.
`define MPSR_CLK_MHZ 25
`define MPSR_CTRL_PERIOD_US 1000
`define MPSR_CTRL_CYCLES (`MPSR_CLK_MHZ * `MPSR_CTRL_PERIOD_US)

// Ramp times are held in tenths of a second, counted in control ticks.
`define MPSR_TENTHS_PER_S 10
`define MPSR_TIME_UNIT_TICKS 100
`define MPSR_RAMP_DEFAULT_S 10
`define MPSR_TIME_RESET 16'(`MPSR_RAMP_DEFAULT_S * `MPSR_TENTHS_PER_S)

// Reference speed in rpm and its negative, the travel limits.
`define MPSR_REF_SPEED 16'h05dc
`define MPSR_REF_NEG (16'h0000 - `MPSR_REF_SPEED)

// Steps taken at half rate while initial rounding is active.
`define MPSR_ROUND_STEPS 8'h10

// Scaling factors are Q2.14: one is this value.
`define MPSR_SCALE_ONE 16'h4000
`define MPSR_SCALE_SHIFT 14

// Reset values.
`define MPSR_CFG_RESET 5'h06
`define MPSR_START_RESET 16'h0000
`define MPSR_RAISE_RESET (`MPSR_HAS_FIELDBUS ? 6'h1d : 6'h00)
`define MPSR_LOWER_RESET (`MPSR_HAS_FIELDBUS ? 6'h1e : 6'h00)

// Register addresses.
`define MPSR_A_CFG 4'h0
`define MPSR_A_RAISE 4'h1
`define MPSR_A_LOWER 4'h2
`define MPSR_A_START 4'h3
`define MPSR_A_UP_TIME 4'h4
`define MPSR_A_DOWN_TIME 4'h5
`define MPSR_A_MAIN_SRC 4'h6
`define MPSR_A_MAIN_SCALE 4'h7
`define MPSR_A_SUPP_SRC 4'h8
`define MPSR_A_SUPP_SCALE 4'h9
`define MPSR_A_RAMPED 4'ha
`define MPSR_A_ACTIVE 4'hb
`define MPSR_A_STATUS 4'hc

`endif

// File: src/mpsr_pkg.sv
package mpsr_pkg;

   typedef enum logic [1:0] {
      MPSR_BIT_ZERO, MPSR_BIT_WORD, MPSR_BIT_DIN
   } mpsr_bit_kind_type;

   typedef struct packed {
      mpsr_bit_kind_type kind;
      logic [3:0] index;
   } mpsr_bitsel_type;

   typedef enum logic [1:0] {
      MPSR_SP_ZERO, MPSR_SP_FIELDBUS, MPSR_SP_ANALOG, MPSR_SP_POT
   } mpsr_sp_src_type;

   typedef enum logic [1:0] {
      MPSR_SC_ZERO, MPSR_SC_ONE, MPSR_SC_ANALOG, MPSR_SC_FIELDBUS
   } mpsr_sc_src_type;

   typedef enum logic [1:0] {
      MPSR_RAMP_IDLE, MPSR_RAMP_ROUND, MPSR_RAMP_LINEAR
   } mpsr_ramp_state_type;

   typedef struct packed {
      logic reserved;
      logic nvram;
      logic rounding;
      logic ramp_auto;
      logic storage;
   } mpsr_cfg_type;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } mpsr_bus_type;

   typedef struct packed {
      logic [15:0] control_word;
      logic [15:0] digital_in;
      logic [15:0] fieldbus_receive_word_two;
      logic [15:0] analog_in0;
   } mpsr_io_type;

endpackage : mpsr_pkg

// File: src/mpsr_ramp.sv
`timescale 1ns/100ps
`include "mpsr_cfg.svh"

module mpsr_ramp (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic tick,
   input wire logic up,
   input wire logic down,
   input wire logic load,
   input wire logic [15:0] load_value,
   input wire logic [15:0] time_up,
   input wire logic [15:0] time_down,
   input wire logic bypass,
   input wire logic rounding,
   output logic [15:0] value
);
   import mpsr_pkg::*;

   mpsr_ramp_state_type state;
   logic [23:0] acc;
   logic [7:0] round_count;
   logic [23:0] span;
   logic [23:0] next_acc;
   logic moving;
   logic jump;
   logic step;

   // The accumulator gains the reference speed each tick; one rpm step is
   // taken each time it passes the ramp span, so the full travel takes the
   // ramp time. Only one step per tick: spans shorter than the reference
   // speed in ticks ramp slower than asked.
   always_comb begin
      moving = up ^ down;
      span = 24'((up ? time_up : time_down) * `MPSR_TIME_UNIT_TICKS);
      // Rounding halves the very first tick too, so no full step escapes.
      if (state == MPSR_RAMP_ROUND ||
          (state == MPSR_RAMP_IDLE && rounding)) begin
         next_acc = acc + 24'(`MPSR_REF_SPEED >> 1);
      end else begin
         next_acc = acc + 24'(`MPSR_REF_SPEED);
      end
      jump = moving && (bypass || span == 24'h00_0000);
      step = tick && moving && !jump && next_acc >= span;
   end

   // Output setpoint; steps and jumps are clamped to plus and minus the reference speed, loads are not.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         value <= `MPSR_START_RESET;
      end else if (load) begin
         value <= load_value;
      end else if (tick && jump) begin
         value <= up ? `MPSR_REF_SPEED : `MPSR_REF_NEG;
      end else if (step) begin
         if (up && $signed(value) < $signed(`MPSR_REF_SPEED)) begin
            value <= value + 16'h0001;
         end else if (down && $signed(value) > $signed(`MPSR_REF_NEG)) begin
            value <= value - 16'h0001;
         end
      end
   end

   // Rate accumulator, cleared whenever the pot stands still.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         acc <= 24'h00_0000;
      end else if (load) begin
         acc <= 24'h00_0000;
      end else if (tick) begin
         if (!moving || jump) begin
            acc <= 24'h00_0000;
         end else if (step) begin
            acc <= next_acc - span;
         end else begin
            acc <= next_acc;
         end
      end
   end

   // Initial rounding: the first steps of each move run at half rate.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= MPSR_RAMP_IDLE;
         round_count <= 8'h00;
      end else if (load) begin
         state <= MPSR_RAMP_IDLE;
         round_count <= 8'h00;
      end else if (tick) begin
         case (state)
            MPSR_RAMP_IDLE: begin
               round_count <= 8'h00;
               if (moving && !jump) begin
                  state <= rounding ? MPSR_RAMP_ROUND : MPSR_RAMP_LINEAR;
               end
            end
            MPSR_RAMP_ROUND: begin
               if (!moving) begin
                  state <= MPSR_RAMP_IDLE;
               end else if (step) begin
                  round_count <= round_count + 8'h01;
                  if (round_count == `MPSR_ROUND_STEPS - 8'h01) begin
                     state <= MPSR_RAMP_LINEAR;
                  end
               end
            end
            MPSR_RAMP_LINEAR: begin
               if (!moving) begin
                  state <= MPSR_RAMP_IDLE;
               end
            end
            default: begin
               state <= MPSR_RAMP_IDLE;
            end
         endcase
      end
   end

endmodule : mpsr_ramp

// File: src/mpsr_top.sv
// Contract
// - Raise command drives setpoint up continuously.
// - Lower command drives setpoint down continuously.
// - Start value register, reset 0 rpm.
// - Ramp-up time register, reset 10 s.
// - Ramp-down time register, reset 10 s.
// - Ramped pot setpoint is readable.
// - Main setpoint source select, fieldbus default.
// - Main scaling source select, default one.
// - Supplementary source select, default zero.
// - Supplementary scaling source select, default zero.
// - Active main setpoint is readable.
// - Configuration resets to 00110 binary.
// - Storage off: load start value at switch-on.
// - Storage on: save at off, restore at on.
// - Auto mode: bit 01 selects ramp or jump.
// - Manual mode always ramps; here a zero ramp time jumps in either mode.
// - Bit 02 enables initial rounding.
// - Bits 03 and 00 keep value nonvolatile.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`include "mpsr_cfg.svh"

module mpsr_top #(
   parameter int CTRL_TICK_CYCLES = `MPSR_CTRL_CYCLES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire mpsr_pkg::mpsr_bus_type bus,
   output logic [15:0] rdata,
   input wire mpsr_pkg::mpsr_io_type io,
   input wire logic motor_on,
   input wire logic automatic_mode_select,
   input wire logic nv_restore_valid,
   input wire logic [15:0] nv_restore_data,
   output logic [15:0] pot_ramped_setpoint,
   output logic [15:0] active_main_setpoint,
   output logic nv_store_req,
   output logic [15:0] nv_store_data
);
   import mpsr_pkg::*;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   mpsr_cfg_type pot_configuration;
   mpsr_bitsel_type pot_raise_source;
   mpsr_bitsel_type pot_lower_source;
   logic [15:0] pot_start_value;
   logic [15:0] pot_ramp_up_time;
   logic [15:0] pot_ramp_down_time;
   mpsr_sp_src_type main_setpoint_source;
   mpsr_sc_src_type main_setpoint_scale_source;
   mpsr_sp_src_type supplementary_setpoint_source;
   mpsr_sc_src_type supplementary_scale_source;
   logic [15:0] saved_setpoint;
   logic [31:0] tick_count;
   logic tick;
   logic motor_on_q;
   logic switch_on;
   logic switch_off;
   logic raise_cmd;
   logic lower_cmd;
   logic ramp_bypass;
   logic [15:0] load_value;
   logic [15:0] main_value;
   logic [15:0] main_scale;
   logic [15:0] supp_value;
   logic [15:0] supp_scale;
   logic [31:0] main_product;
   logic [31:0] supp_product;
   logic [17:0] sum;
   logic [15:0] next_active;
   logic wr_hit;

   // Picks one command bit from the control word or the digital inputs.
   function automatic logic pick_bit(mpsr_bitsel_type sel,
                                     mpsr_io_type src);
      logic result;
      result = 1'b0;
      case (sel.kind)
         MPSR_BIT_WORD: result = src.control_word[sel.index];
         MPSR_BIT_DIN: result = src.digital_in[sel.index];
         default: result = 1'b0;
      endcase
      return result;
   endfunction : pick_bit

   // Setpoint source multiplexer shared by main and supplementary paths.
   function automatic logic [15:0] pick_sp(mpsr_sp_src_type sel,
                                           mpsr_io_type src,
                                           logic [15:0] pot);
      logic [15:0] result;
      result = 16'h0000;
      case (sel)
         MPSR_SP_FIELDBUS: result = src.fieldbus_receive_word_two;
         MPSR_SP_ANALOG: result = src.analog_in0;
         MPSR_SP_POT: result = pot;
         default: result = 16'h0000;
      endcase
      return result;
   endfunction : pick_sp

   // Scaling source multiplexer; the constants are zero and one in Q2.14.
   function automatic logic [15:0] pick_sc(mpsr_sc_src_type sel,
                                           mpsr_io_type src);
      logic [15:0] result;
      result = 16'h0000;
      case (sel)
         MPSR_SC_ONE: result = `MPSR_SCALE_ONE;
         MPSR_SC_ANALOG: result = src.analog_in0;
         MPSR_SC_FIELDBUS: result = src.fieldbus_receive_word_two;
         default: result = 16'h0000;
      endcase
      return result;
   endfunction : pick_sc

   // Control-cycle divider: one tick pulse per control period.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         tick_count <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (tick_count >= 32'(CTRL_TICK_CYCLES - 1)) begin
         tick_count <= 32'h0000_0000;
         tick <= 1'b1;
      end else begin
         tick_count <= tick_count + 32'h0000_0001;
         tick <= 1'b0;
      end
   end

   assign wr_hit = bus.wr;

   // Parameter registers written by software.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pot_configuration <= `MPSR_CFG_RESET;
         pot_raise_source <= `MPSR_RAISE_RESET;
         pot_lower_source <= `MPSR_LOWER_RESET;
         pot_start_value <= `MPSR_START_RESET;
         pot_ramp_up_time <= `MPSR_TIME_RESET;
         pot_ramp_down_time <= `MPSR_TIME_RESET;
      end else if (wr_hit) begin
         case (bus.addr)
            `MPSR_A_CFG: pot_configuration <= bus.wdata[4:0];
            `MPSR_A_RAISE: pot_raise_source <= bus.wdata[5:0];
            `MPSR_A_LOWER: pot_lower_source <= bus.wdata[5:0];
            `MPSR_A_START: pot_start_value <= bus.wdata;
            `MPSR_A_UP_TIME: pot_ramp_up_time <= bus.wdata;
            `MPSR_A_DOWN_TIME: pot_ramp_down_time <= bus.wdata;
            default: ;
         endcase
      end
   end

   // Source selectors; the main default follows the fieldbus build option.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         main_setpoint_source <= `MPSR_HAS_FIELDBUS ?
            MPSR_SP_FIELDBUS : MPSR_SP_ANALOG;
         main_setpoint_scale_source <= MPSR_SC_ONE;
         supplementary_setpoint_source <= MPSR_SP_ZERO;
         supplementary_scale_source <= MPSR_SC_ZERO;
      end else if (wr_hit) begin
         case (bus.addr)
            `MPSR_A_MAIN_SRC:
               main_setpoint_source <= mpsr_sp_src_type'(bus.wdata[1:0]);
            `MPSR_A_MAIN_SCALE:
               main_setpoint_scale_source <=
                  mpsr_sc_src_type'(bus.wdata[1:0]);
            `MPSR_A_SUPP_SRC:
               supplementary_setpoint_source <=
                  mpsr_sp_src_type'(bus.wdata[1:0]);
            `MPSR_A_SUPP_SCALE:
               supplementary_scale_source <=
                  mpsr_sc_src_type'(bus.wdata[1:0]);
            default: ;
         endcase
      end
   end

   // Read port: data stand in the cycle after the strobe only.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= 16'h0000;
      end else if (!bus.rd) begin
         rdata <= 16'h0000;
      end else begin
         case (bus.addr)
            `MPSR_A_CFG: rdata <= {11'h000, pot_configuration};
            `MPSR_A_RAISE: rdata <= {10'h000, pot_raise_source};
            `MPSR_A_LOWER: rdata <= {10'h000, pot_lower_source};
            `MPSR_A_START: rdata <= pot_start_value;
            `MPSR_A_UP_TIME: rdata <= pot_ramp_up_time;
            `MPSR_A_DOWN_TIME: rdata <= pot_ramp_down_time;
            `MPSR_A_MAIN_SRC: rdata <= {14'h0000, main_setpoint_source};
            `MPSR_A_MAIN_SCALE:
               rdata <= {14'h0000, main_setpoint_scale_source};
            `MPSR_A_SUPP_SRC:
               rdata <= {14'h0000, supplementary_setpoint_source};
            `MPSR_A_SUPP_SCALE:
               rdata <= {14'h0000, supplementary_scale_source};
            `MPSR_A_RAMPED: rdata <= pot_ramped_setpoint;
            `MPSR_A_ACTIVE: rdata <= active_main_setpoint;
            `MPSR_A_STATUS: rdata <= {12'h000, automatic_mode_select,
                                      lower_cmd, raise_cmd, motor_on};
            default: rdata <= 16'h0000;
         endcase
      end
   end

   a_read_ramped: assert property (
      bus.rd && bus.addr == `MPSR_A_RAMPED
      |=> rdata == $past(pot_ramped_setpoint))
      else $error("ramped setpoint read back wrong");

   // Motor switch edges.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         motor_on_q <= 1'b0;
      end else begin
         motor_on_q <= motor_on;
      end
   end

   assign switch_on = motor_on && !motor_on_q;
   assign switch_off = !motor_on && motor_on_q;

   // Commands; equal commands cancel and leave the ramp at rest.
   assign raise_cmd = pick_bit(pot_raise_source, io);
   assign lower_cmd = pick_bit(pot_lower_source, io);

   // Ramp bypass only in automatic mode with bit 01 clear.
   assign ramp_bypass = automatic_mode_select &&
                        !pot_configuration.ramp_auto;

   // Storage picks the saved value over the start value at switch-on.
   assign load_value = pot_configuration.storage ?
                       saved_setpoint : pot_start_value;

   // Stored setpoint. A restore from nonvolatile memory is taken only when
   // both storage bits are set, so a stale image cannot creep in.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         saved_setpoint <= `MPSR_START_RESET;
      end else if (switch_off && pot_configuration.storage) begin
         saved_setpoint <= pot_ramped_setpoint;
      end else if (nv_restore_valid && pot_configuration.storage &&
                   pot_configuration.nvram) begin
         saved_setpoint <= nv_restore_data;
      end
   end

   // Nonvolatile write request, one cycle, raised at switch-off.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         nv_store_req <= 1'b0;
         nv_store_data <= 16'h0000;
      end else begin
         nv_store_req <= switch_off && pot_configuration.storage &&
                         pot_configuration.nvram;
         if (switch_off) begin
            nv_store_data <= pot_ramped_setpoint;
         end
      end
   end

   a_nv_store: assert property (
      switch_off && pot_configuration.storage && pot_configuration.nvram
      |=> nv_store_req && nv_store_data == saved_setpoint)
      else $error("nonvolatile store missing at switch-off");

   // Ramp generator; steps once per control tick at most.
   mpsr_ramp u_ramp (
      .clock(clock),
      .rst_b(rst_b),
      .tick(tick),
      .up(raise_cmd),
      .down(lower_cmd),
      .load(switch_on),
      .load_value(load_value),
      .time_up(pot_ramp_up_time),
      .time_down(pot_ramp_down_time),
      .bypass(ramp_bypass),
      .rounding(pot_configuration.rounding),
      .value(pot_ramped_setpoint)
   );

   a_raise_no_fall: assert property (
      raise_cmd && !lower_cmd && !switch_on
      |=> $signed(pot_ramped_setpoint) >= $signed($past(pot_ramped_setpoint)))
      else $error("setpoint fell while raising");

   a_lower_no_rise: assert property (
      lower_cmd && !raise_cmd && !switch_on
      |=> $signed(pot_ramped_setpoint) <= $signed($past(pot_ramped_setpoint)))
      else $error("setpoint rose while lowering");

   a_equal_cmd_hold: assert property (
      raise_cmd == lower_cmd && !switch_on |=> $stable(pot_ramped_setpoint))
      else $error("setpoint moved without a single command");

   a_start_load: assert property (
      switch_on && !pot_configuration.storage
      |=> pot_ramped_setpoint == $past(pot_start_value))
      else $error("start value not loaded at switch-on");

   a_restore_saved: assert property (
      switch_on && pot_configuration.storage
      |=> pot_ramped_setpoint == $past(saved_setpoint))
      else $error("saved value not restored at switch-on");

   a_bypass_jump: assert property (
      tick && ramp_bypass && raise_cmd && !lower_cmd && !switch_on
      |=> pot_ramped_setpoint == `MPSR_REF_SPEED)
      else $error("automatic mode without ramp did not jump");

   a_manual_slew: assert property (
      tick && !automatic_mode_select && raise_cmd && !lower_cmd &&
      pot_ramp_up_time != 16'h0000 && !switch_on
      |=> pot_ramped_setpoint - $past(pot_ramped_setpoint) <= 16'h0001)
      else $error("manual mode stepped faster than the ramp");

   a_tick_spacing: assert property (
      tick |=> !tick)
      else $error("control tick longer than one cycle");

   c_raise_move: cover property (
      raise_cmd && !lower_cmd ##1 $changed(pot_ramped_setpoint));
   c_switch_restore: cover property (
      switch_on && pot_configuration.storage);
   c_nv_store: cover property (nv_store_req);

   // Main and supplementary paths, each scaled in Q2.14.
   always_comb begin
      main_value = pick_sp(main_setpoint_source, io,
                           pot_ramped_setpoint);
      main_scale = pick_sc(main_setpoint_scale_source, io);
      supp_value = pick_sp(supplementary_setpoint_source, io,
                           pot_ramped_setpoint);
      supp_scale = pick_sc(supplementary_scale_source, io);
      main_product = 32'($signed(main_value) * $signed(main_scale));
      supp_product = 32'($signed(supp_value) * $signed(supp_scale));
      sum = 18'($signed(main_product) >>> `MPSR_SCALE_SHIFT) +
            18'($signed(supp_product) >>> `MPSR_SCALE_SHIFT);
   end

   // Saturate the sum rather than wrap, so a large trim cannot flip sign.
   always_comb begin
      if ($signed(sum) > $signed(18'h0_7fff)) begin
         next_active = 16'h7fff;
      end else if ($signed(sum) < $signed(18'h3_8000)) begin
         next_active = 16'h8000;
      end else begin
         next_active = sum[15:0];
      end
   end

   // Registered active main setpoint.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         active_main_setpoint <= 16'h0000;
      end else begin
         active_main_setpoint <= next_active;
      end
   end

   a_unity_scale: assert property (
      main_setpoint_scale_source == MPSR_SC_ONE &&
      supplementary_scale_source == MPSR_SC_ZERO
      |=> active_main_setpoint == $past(main_value))
      else $error("unity scaling changed the main setpoint");

   c_active_sum: cover property (
      supplementary_scale_source != MPSR_SC_ZERO
      ##1 active_main_setpoint != 16'h0000);

endmodule : mpsr_top
